// [src/odp_pkg.sv]
// Package for the open-drain port set: pin layout, instruction codes,
// register map and reset values.
// Assumes a single aclk domain and an AXI4-Lite register slave.
package odp_pkg;

  // One bit per physical pin, grouped by port
  typedef struct packed {
    logic [3:0] quad0;
    logic [3:0] quad1;
    logic [1:0] pair2;
    logic [1:0] pair3;
    logic [5:0] dbit;
  } odp_pin_t;

  typedef enum logic [4:0] {
    OP_NOP           = 5'h00,
    OP_OUT_QUAD_0    = 5'h01,
    OP_IN_QUAD_0     = 5'h02,
    OP_OUT_QUAD_1    = 5'h03,
    OP_IN_QUAD_1     = 5'h04,
    OP_OUT_PAIR_2    = 5'h05,
    OP_IN_PAIR_2     = 5'h06,
    OP_OUT_PAIR_3    = 5'h07,
    OP_IN_PAIR_3     = 5'h08,
    OP_SET_D_LATCH   = 5'h09,
    OP_CLEAR_D_LATCH = 5'h0A,
    OP_CLEAR_ALL_D   = 5'h0B,
    OP_SKIP_IF_D_0   = 5'h0C,
    OP_SET_SKIP      = 5'h0D,
    OP_RESET_SKIP    = 5'h0E,
    OP_SKIP_IF_C_1   = 5'h0F,
    OP_OUT_KEY       = 5'h10,
    OP_IN_KEY        = 5'h11
  } odp_op_t;

  // Instruction issued by the CPU core, with accumulator and Y
  typedef struct packed {
    odp_op_t    op;
    logic [3:0] acc;
    logic [3:0] y;
  } odp_cmd_t;

  // Result handed back to the CPU core
  typedef struct packed {
    logic       acc_we;
    logic [3:0] acc;
    logic       skip;
  } odp_res_t;

  localparam int D_PINS = 6;
  localparam int SKIP_SHARE_IDX = 2;
  localparam int KEY_SHARE_IDX = 3;
  localparam int TIMER_PIN_IDX = 2;

  // Register byte offsets
  localparam logic [7:0] OFF_WAKE_MASK_0 = 8'h00;
  localparam logic [7:0] OFF_PULLUP_CTL_0 = 8'h04;
  localparam logic [7:0] OFF_WAKE_MASK_1 = 8'h08;
  localparam logic [7:0] OFF_PULLUP_CTL_1 = 8'h0C;
  localparam logic [7:0] OFF_WAKE_BITS_2 = 8'h10;
  localparam logic [7:0] OFF_PULLUP_BITS_2 = 8'h14;
  localparam logic [7:0] OFF_TIMER_CTL = 8'h18;
  localparam logic [7:0] OFF_PIN_LEVEL = 8'h1C;
  localparam logic [7:0] OFF_LATCH_STATE = 8'h20;

  // Fields of the latch state register
  localparam int LS_SKIP_BIT = 18;
  localparam int LS_KEY_BIT = 19;

  localparam logic [3:0] RST_CTL4 = 4'h0;
  localparam logic RST_TIMER_EN = 1'b0;
  localparam logic [3:0] RST_LATCH4 = 4'hF;
  localparam logic [1:0] RST_LATCH2 = 2'h3;
  localparam logic [5:0] RST_LATCH6 = 6'h3F;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [src/odp_port_set.sv]
// Open-drain general-purpose port set of a small 4-bit controller, with
// its wakeup, pull-up and timer-pin control reached over AXI4-Lite.
// Assumes pin inputs synchronous to aclk and a CPU core that issues one
// instruction at a time on cmd_valid.
//
// Contract
// [RULE1] quad_port_0 is 4 bits; wake_mask_0 and pullup_ctl_0 gate its pins.
// [RULE2] out_quad_0 copies acc to latches; in_quad_0 loads pins into acc.
// [RULE3] A pin reads as input only while its latch is 1; 0 reads low.
// [RULE4] Outputs are open-drain: 0 pulls low, 1 releases, never drives high.
// [RULE5] quad_port_1 is a 4-bit port with wake_mask_1 and pullup_ctl_1.
// [RULE6] Software holds timer_pin_out_en at 0 to use quad_port_1 bit 2.
// [RULE7] out_pair_2 writes pair_port_2; in_pair_2 reads 2 bits, upper 0.
// [RULE8] pair_port_2 pins have wake bits 20, 21 and pull-up bits 20, 21.
// [RULE9] pair_port_3 has no wakeup or pull-up; in_pair_3 clears upper bits.
// [RULE10] Six 1-bit ports bit_ports_d, each addressed by the Y register.
// [RULE11] skip_if_d_zero skips the next op when the selected pin reads 0.
// [RULE12] set_d_latch writes 1 to the selected latch; clear_d_latch writes 0.
// [RULE13] clear_all_d writes 1 to all six bit_ports_d latches at once.
// [RULE14] Software never sets or clears a d latch with Y at 6 or above.
// [RULE15] bit_ports_d pins 2, 3 have wake bits 22, 23 and pull-ups 22, 23.
// [RULE16] skip_port shares d pin 2; either latch at 0 pulls the pin low.
// [RULE17] skip_port is 1-bit; set_skip_latch sets 1, reset_skip_latch sets 0.
// [RULE18] skip_if_c_one skips the next op when the skip_port pin reads 1.
// [RULE19] key_port: out_key copies acc bit 0; in_key zeroes acc bits 1 to 3.
// [RULE20] key_port shares d pin 3; either latch at 0 pulls the pin low.
// [RULE21] wake_mask_0 is a read-write 4-bit register reset to zero.
// [RULE22] pullup_ctl_0 is a write-only 4-bit register reset to zero.
// [RULE23] All output latches reset to 1, releasing every pin.

module odp_port_set #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // CPU instruction side
  input wire logic cmd_valid,
  input wire odp_pkg::odp_cmd_t cmd,
  output odp_pkg::odp_res_t res,
  // Pins
  input wire odp_pkg::odp_pin_t pins_i,
  output odp_pkg::odp_pin_t pins_o,
  output odp_pkg::odp_pin_t pins_oe,
  output odp_pkg::odp_pin_t pullup_en,
  output logic key_wake,
  input wire logic timer_pin_level,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by several instructions and by both AXI4-Lite channels

  // One-hot select of a d pin; out-of-range Y selects nothing
  function automatic logic [odp_pkg::D_PINS-1:0] d_select(
    input logic [3:0] y
  );
    logic [odp_pkg::D_PINS-1:0] sel;
    sel = '0;
    for (int i = 0; i < odp_pkg::D_PINS; i++) begin
      if (y == 4'(i)) begin
        sel[i] = 1'b1;
      end
    end
    return sel;
  endfunction

  function automatic logic in_map(input logic [7:0] a);
    return a == odp_pkg::OFF_WAKE_MASK_0 || a == odp_pkg::OFF_PULLUP_CTL_0 ||
      a == odp_pkg::OFF_WAKE_MASK_1 || a == odp_pkg::OFF_PULLUP_CTL_1 ||
      a == odp_pkg::OFF_WAKE_BITS_2 || a == odp_pkg::OFF_PULLUP_BITS_2 ||
      a == odp_pkg::OFF_TIMER_CTL || a == odp_pkg::OFF_PIN_LEVEL ||
      a == odp_pkg::OFF_LATCH_STATE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Output latches

  logic [3:0] quad0_q;
  logic [3:0] quad1_q;
  logic [1:0] pair2_q;
  logic [1:0] pair3_q;
  logic [odp_pkg::D_PINS-1:0] dlat_q;
  logic skip_lat_q;
  logic key_lat_q;
  logic [odp_pkg::D_PINS-1:0] ysel;
  logic do_cmd;

  assign ysel = d_select(cmd.y);
  assign do_cmd = ce && cmd_valid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quad0_q <= odp_pkg::RST_LATCH4; // RULE23
      quad1_q <= odp_pkg::RST_LATCH4;
      pair2_q <= odp_pkg::RST_LATCH2;
      pair3_q <= odp_pkg::RST_LATCH2;
    end else if (do_cmd) begin
      unique case (cmd.op)
        odp_pkg::OP_OUT_QUAD_0: quad0_q <= cmd.acc; // RULE2
        odp_pkg::OP_OUT_QUAD_1: quad1_q <= cmd.acc; // RULE5
        odp_pkg::OP_OUT_PAIR_2: pair2_q <= cmd.acc[1:0]; // RULE7
        odp_pkg::OP_OUT_PAIR_3: pair3_q <= cmd.acc[1:0]; // RULE9
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dlat_q <= odp_pkg::RST_LATCH6; // RULE23
    end else if (do_cmd) begin
      unique case (cmd.op)
        // Out-of-range Y touches no latch, so a stray write is harmless
        odp_pkg::OP_SET_D_LATCH: dlat_q <= dlat_q | ysel; // RULE12 RULE10
        odp_pkg::OP_CLEAR_D_LATCH: dlat_q <= dlat_q & ~ysel; // RULE12 RULE14
        odp_pkg::OP_CLEAR_ALL_D: dlat_q <= odp_pkg::RST_LATCH6; // RULE13
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_lat_q <= 1'b1; // RULE23
      key_lat_q <= 1'b1;
    end else if (do_cmd) begin
      unique case (cmd.op)
        odp_pkg::OP_SET_SKIP: skip_lat_q <= 1'b1; // RULE17
        odp_pkg::OP_RESET_SKIP: skip_lat_q <= 1'b0; // RULE17
        odp_pkg::OP_OUT_KEY: key_lat_q <= cmd.acc[0]; // RULE19
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [3:0] wake_mask_0_q;
  logic [3:0] pullup_ctl_0_q;
  logic [3:0] wake_mask_1_q;
  logic [3:0] pullup_ctl_1_q;
  logic [3:0] wake_bits_2_q;
  logic [3:0] pullup_bits_2_q;
  logic timer_pin_out_en_q;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_mask_0_q <= odp_pkg::RST_CTL4; // RULE21
      pullup_ctl_0_q <= odp_pkg::RST_CTL4; // RULE22
      wake_mask_1_q <= odp_pkg::RST_CTL4;
      pullup_ctl_1_q <= odp_pkg::RST_CTL4;
      wake_bits_2_q <= odp_pkg::RST_CTL4;
      pullup_bits_2_q <= odp_pkg::RST_CTL4;
      timer_pin_out_en_q <= odp_pkg::RST_TIMER_EN;
    end else if (wr_fire) begin
      unique case (wr_addr)
        odp_pkg::OFF_WAKE_MASK_0: wake_mask_0_q <= wr_data[3:0]; // RULE21
        odp_pkg::OFF_PULLUP_CTL_0: pullup_ctl_0_q <= wr_data[3:0]; // RULE22
        odp_pkg::OFF_WAKE_MASK_1: wake_mask_1_q <= wr_data[3:0];
        odp_pkg::OFF_PULLUP_CTL_1: pullup_ctl_1_q <= wr_data[3:0];
        odp_pkg::OFF_WAKE_BITS_2: wake_bits_2_q <= wr_data[3:0];
        odp_pkg::OFF_PULLUP_BITS_2: pullup_bits_2_q <= wr_data[3:0];
        odp_pkg::OFF_TIMER_CTL: timer_pin_out_en_q <= wr_data[0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, pull-ups and wakeup

  odp_pkg::odp_pin_t shared_low;

  // The timer drives its shared pin open-drain too, never high
  assign shared_low.quad0 = ~quad0_q; // RULE1 RULE4
  assign shared_low.quad1 = ~quad1_q |
    ((timer_pin_out_en_q && !timer_pin_level) ?
     4'(1 << odp_pkg::TIMER_PIN_IDX) : 4'h0); // RULE5 RULE6
  assign shared_low.pair2 = ~pair2_q; // RULE7
  assign shared_low.pair3 = ~pair3_q; // RULE9

  genvar gi;
  generate
    for (gi = 0; gi < odp_pkg::D_PINS; gi++) begin : g_dpin
      if (gi == odp_pkg::SKIP_SHARE_IDX) begin : g_skip
        assign shared_low.dbit[gi] = !dlat_q[gi] || !skip_lat_q; // RULE16
      end else if (gi == odp_pkg::KEY_SHARE_IDX) begin : g_key
        assign shared_low.dbit[gi] = !dlat_q[gi] || !key_lat_q; // RULE20
      end else begin : g_plain
        assign shared_low.dbit[gi] = !dlat_q[gi]; // RULE10
      end
    end
  endgenerate

  // Open drain: data is always low, the enable alone pulls the pin
  assign pins_o = '0; // RULE4
  assign pins_oe = shared_low; // RULE3 RULE4

  assign pullup_en.quad0 = pullup_ctl_0_q; // RULE1 RULE22
  assign pullup_en.quad1 = pullup_ctl_1_q; // RULE5
  assign pullup_en.pair2 = pullup_bits_2_q[1:0]; // RULE8
  assign pullup_en.pair3 = 2'h0; // RULE9
  assign pullup_en.dbit = {2'h0, pullup_bits_2_q[3:2], 2'h0}; // RULE15

  // Level wake request: any enabled pin seen low
  logic [15:0] wake_en;
  logic [15:0] wake_lvl;
  assign wake_en = {wake_mask_0_q, wake_mask_1_q, wake_bits_2_q[1:0],
                    wake_bits_2_q[3:2], 4'h0}; // RULE1 RULE5 RULE8 RULE15
  assign wake_lvl = {pins_i.quad0, pins_i.quad1, pins_i.pair2,
                     pins_i.dbit[3:2], 4'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_wake <= 1'b0;
    end else if (ce) begin
      key_wake <= |(wake_en & ~wake_lvl);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction results, one cycle after the instruction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res <= '0;
    end else if (ce) begin
      res <= '0;
      if (cmd_valid) begin
        unique case (cmd.op)
          odp_pkg::OP_IN_QUAD_0: res <= '{1'b1, pins_i.quad0, 1'b0}; // RULE2
          odp_pkg::OP_IN_QUAD_1: res <= '{1'b1, pins_i.quad1, 1'b0}; // RULE5
          odp_pkg::OP_IN_PAIR_2:
            res <= '{1'b1, {2'h0, pins_i.pair2}, 1'b0}; // RULE7
          odp_pkg::OP_IN_PAIR_3:
            res <= '{1'b1, {2'h0, pins_i.pair3}, 1'b0}; // RULE9
          odp_pkg::OP_IN_KEY:
            res <= '{1'b1, {3'h0, pins_i.dbit[odp_pkg::KEY_SHARE_IDX]},
                     1'b0}; // RULE19
          odp_pkg::OP_SKIP_IF_D_0:
            res <= '{1'b0, 4'h0, |(ysel & ~pins_i.dbit)}; // RULE11
          odp_pkg::OP_SKIP_IF_C_1:
            res <= '{1'b0, 4'h0,
                     pins_i.dbit[odp_pkg::SKIP_SHARE_IDX]}; // RULE18
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = ce && aw_held_q && w_held_q && !s_axi_bvalid &&
    wstrb0_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= odp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (aw_held_q && w_held_q && !s_axi_bvalid) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= in_map(awaddr_q) ? odp_pkg::RESP_OKAY :
          odp_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic [31:0] rd_mux;
  logic [7:0] rd_addr;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_addr = 8'(s_axi_araddr);

  // Pull-up registers are write-only and read back as zero
  always_comb begin
    rd_mux = '0;
    unique case (rd_addr)
      odp_pkg::OFF_WAKE_MASK_0: rd_mux = {28'h0, wake_mask_0_q}; // RULE21
      odp_pkg::OFF_WAKE_MASK_1: rd_mux = {28'h0, wake_mask_1_q};
      odp_pkg::OFF_WAKE_BITS_2: rd_mux = {28'h0, wake_bits_2_q};
      odp_pkg::OFF_TIMER_CTL: rd_mux = {31'h0, timer_pin_out_en_q};
      odp_pkg::OFF_PIN_LEVEL: rd_mux = {14'h0, pins_i};
      odp_pkg::OFF_LATCH_STATE:
        rd_mux = {12'h0, key_lat_q, skip_lat_q, quad0_q, quad1_q, pair2_q,
                  pair3_q, dlat_q};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= odp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= in_map(rd_addr) ? odp_pkg::RESP_OKAY :
          odp_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [sim/odp_pin_model.sv]
// Pin-side partner of the open-drain port set: the level that each pin
// settles to.
// Assumes the bench drives the outside level and every idle pin is pulled up.
module odp_pin_model (
  input wire odp_pkg::odp_pin_t pins_o,
  input wire odp_pkg::odp_pin_t pins_oe,
  input wire odp_pkg::odp_pin_t ext_lvl,
  output odp_pkg::odp_pin_t pins_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired-AND: an on-chip pull-down wins over the outside level. A chip
  // that drove high would show through here too.
  assign pins_i = (pins_oe & pins_o) | (~pins_oe & ext_lvl);
endmodule

// [sim/odp_chk.sv]
// Concurrent checks on the open-drain port set, bound to its top module.
// Assumes one aclk domain; latch checks expect an idle cycle after the op.
module odp_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire odp_pkg::odp_cmd_t cmd,
  input wire odp_pkg::odp_res_t res,
  input wire odp_pkg::odp_pin_t pins_i,
  input wire odp_pkg::odp_pin_t pins_o,
  input wire odp_pkg::odp_pin_t pins_oe,
  input wire odp_pkg::odp_pin_t pullup_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire take = ce && cmd_valid;
  logic dsel_q;
  logic cpin_q;
  always_ff @(posedge aclk) begin
    dsel_q <= pins_i.dbit[cmd.y[2:0]];
    cpin_q <= pins_i.dbit[2];
  end
  sequence s_op(odp_pkg::odp_op_t o);
    take && cmd.op == o;
  endsequence
  // Latch effects may land one or two edges late, so demand a quiet cycle
  sequence s_lone(odp_pkg::odp_op_t o);
    s_op(o) ##1 !cmd_valid;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  drain_only_a: assert property (pins_o == '0)
    else $error("pin driven high");
  reset_release_a: assert property ($rose(aresetn) |->
    pins_oe == '0 && pullup_en == '0) else $error("pins held after reset");
  res_idle_a: assert property (!take |=> res == '0)
    else $error("result without instruction");
  in_quad_a: assert property (s_op(odp_pkg::OP_IN_QUAD_0) |=>
    res.acc_we && res.acc == $past(pins_i.quad0)) else $error("quad read");
  in_pair_a: assert property (s_op(odp_pkg::OP_IN_PAIR_2) |=>
    res.acc == {2'h0, $past(pins_i.pair2)}) else $error("pair2 read");
  pair3_read_a: assert property (s_op(odp_pkg::OP_IN_PAIR_3) |=>
    res.acc == {2'h0, $past(pins_i.pair3)}) else $error("pair3 read");
  key_read_a: assert property (s_op(odp_pkg::OP_IN_KEY) |=>
    res.acc == {3'h0, $past(pins_i.dbit[3])}) else $error("key read");
  d_skip_a: assert property (s_op(odp_pkg::OP_SKIP_IF_D_0) ##0
    cmd.y < 4'h6 |=> res.skip == !dsel_q) else $error("d skip wrong");
  c_skip_a: assert property (s_op(odp_pkg::OP_SKIP_IF_C_1) |=>
    res.skip == cpin_q) else $error("c skip wrong");
  all_release_a: assert property (s_lone(odp_pkg::OP_CLEAR_ALL_D) |->
    ##[1:2] pins_oe.dbit == '0) else $error("d pins not released");
  skip_low_a: assert property (s_lone(odp_pkg::OP_RESET_SKIP) |->
    ##[1:2] pins_oe.dbit[2]) else $error("skip pin not pulled low");
endmodule

bind odp_port_set odp_chk u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .cmd_valid(cmd_valid), .cmd(cmd), .res(res), .pins_i(pins_i),
  .pins_o(pins_o), .pins_oe(pins_oe), .pullup_en(pullup_en));

// [sim/odp_port_set_tb.sv]
// Self-checking bench for the open-drain port set: CPU ops, pins, registers.
// Assumes the pin model closes the open-drain loop and the core is enabled.
module odp_port_set_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0, aresetn = 1'h0, cmd_valid = 1'h0, key_wake;
  logic ce = 1'h1, tpl = 1'h1;
  odp_pkg::odp_cmd_t cmd = '0;
  odp_pkg::odp_res_t res, r;
  odp_pkg::odp_pin_t pins_i, pins_o, pins_oe, pullup_en, ext = '1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic awr, wr, bvalid, arr, rvalid;
  logic [1:0] bresp, rresp, rs;
  int fail_count = 0, samples_checked = 0;
  int lo[4] = '{14, 10, 8, 6};
  always #4 aclk = ~aclk;
  odp_port_set u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .cmd_valid(cmd_valid), .cmd(cmd), .res(res), .pins_i(pins_i),
    .pins_o(pins_o), .pins_oe(pins_oe), .pullup_en(pullup_en),
    .key_wake(key_wake), .timer_pin_level(tpl), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  odp_pin_model u_pins (.pins_o(pins_o), .pins_oe(pins_oe),
    .ext_lvl(ext), .pins_i(pins_i));
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One instruction; the result stands for one cycle only, so catch it
  // right after the taking edge, then leave an idle cycle
  task automatic exec(input odp_pkg::odp_op_t o, input logic [3:0] a, y);
    @(posedge aclk);
    cmd <= '{o, a, y};
    cmd_valid <= 1'h1;
    @(posedge aclk);
    cmd_valid <= 1'h0;
    #1 r = res;
    @(posedge aclk);
    #1;
  endtask
  // Ready is looked at mid-cycle, where it is settled for the coming edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge aclk);
      ah = awv & awr;
      wh = wv & wr;
      @(posedge aclk);
      if (ah) awv <= 1'h0;
      if (wh) wv <= 1'h0;
    end while (awv & ~ah | wv & ~wh);
    do begin
      @(negedge aclk);
      ah = bvalid;
      rs = bresp;
      @(posedge aclk);
    end while (!ah);
    bready <= 1'h0;
    #1;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ah;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge aclk);
      ah = arr;
      @(posedge aclk);
    end while (!ah);
    arv <= 1'h0;
    do begin
      @(negedge aclk);
      ah = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
    end while (!ah);
    rready <= 1'h0;
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("reset oe", 32'h0, pins_oe);
    chk("reset pullup", 32'h0, pullup_en);
    axi_rd(odp_pkg::OFF_WAKE_MASK_0);
    chk("reset wake0", 32'h0, rd);
  endtask
  task automatic t_regs;
    axi_wr(odp_pkg::OFF_WAKE_MASK_0, 32'hA);
    axi_rd(odp_pkg::OFF_WAKE_MASK_0);
    chk("wake0", 32'hA, rd);
    axi_wr(odp_pkg::OFF_PULLUP_CTL_0, 32'h5);
    chk("pullup0 pins", 32'h5, pullup_en.quad0);
    axi_rd(odp_pkg::OFF_PULLUP_CTL_0);
    chk("pullup0 read", 32'h0, rd);
    axi_wr(odp_pkg::OFF_PULLUP_CTL_1, 32'h3);
    chk("pullup1 pins", 32'h3, pullup_en.quad1);
    axi_wr(odp_pkg::OFF_PULLUP_BITS_2, 32'hE);
    chk("pullup2x", 32'hE, {pullup_en.dbit[3:2], pullup_en.pair2});
    axi_wr(odp_pkg::OFF_WAKE_BITS_2, 32'h9);
    axi_rd(odp_pkg::OFF_WAKE_BITS_2);
    chk("wake2x", 32'h9, rd);
    axi_wr(odp_pkg::OFF_TIMER_CTL, 32'h1);
    chk("timer ctl resp", 32'h0, rs);
    @(posedge aclk);
    tpl <= 1'h0;
    #1 chk("timer pull", 32'h4, pins_oe.quad1);
    @(posedge aclk);
    tpl <= 1'h1;
    axi_wr(odp_pkg::OFF_TIMER_CTL, 32'h0);
    chk("timer off", 32'h0, pins_oe.quad1);
    axi_wr(8'h40, 32'h1);
    chk("wr unmapped", 32'h2, rs);
    axi_rd(8'h40);
    chk("unmapped", 32'h2, rs);
  endtask
  task automatic t_ports;
    logic [3:0] m;
    for (int k = 0; k < 4; k++) begin
      m = k < 2 ? 4'hF : 4'h3;
      exec(odp_pkg::odp_op_t'(5'h01 + 5'(2 * k)), 4'h6, 4'h0);
      chk("port oe", ~4'h6 & m, (pins_oe >> lo[k]) & m);
      exec(odp_pkg::odp_op_t'(5'h02 + 5'(2 * k)), 4'h0, 4'h0);
      chk("port in", 4'h6 & m, r.acc);
      exec(odp_pkg::odp_op_t'(5'h01 + 5'(2 * k)), 4'hF, 4'h0);
    end
  endtask
  task automatic t_dbits;
    for (int y = 0; y < 6; y++) begin
      exec(odp_pkg::OP_CLEAR_D_LATCH, 4'h0, 4'(y));
      chk("d oe", 6'h1 << y, pins_oe.dbit);
      exec(odp_pkg::OP_SKIP_IF_D_0, 4'h0, 4'(y));
      chk("d skip low", 32'h1, r.skip);
      exec(odp_pkg::OP_SET_D_LATCH, 4'h0, 4'(y));
      chk("d oe", 32'h0, pins_oe.dbit);
      exec(odp_pkg::OP_SKIP_IF_D_0, 4'h0, 4'(y));
      chk("d skip high", 32'h0, r.skip);
    end
    exec(odp_pkg::OP_CLEAR_D_LATCH, 4'h0, 4'h1);
    exec(odp_pkg::OP_CLEAR_D_LATCH, 4'h0, 4'h4);
    exec(odp_pkg::OP_CLEAR_D_LATCH, 4'h0, 4'h6);
    chk("d y6", 32'h12, pins_oe.dbit);
    exec(odp_pkg::OP_CLEAR_ALL_D, 4'h0, 4'h0);
    chk("d all", 32'h0, pins_oe.dbit);
  endtask
  task automatic t_shared;
    exec(odp_pkg::OP_RESET_SKIP, 4'h0, 4'h0);
    chk("c oe", 32'h1, pins_oe.dbit[2]);
    exec(odp_pkg::OP_SKIP_IF_C_1, 4'h0, 4'h0);
    chk("c skip low", 32'h0, r.skip);
    exec(odp_pkg::OP_SET_SKIP, 4'h0, 4'h0);
    chk("c oe", 32'h0, pins_oe.dbit[2]);
    exec(odp_pkg::OP_SKIP_IF_C_1, 4'h0, 4'h0);
    chk("c skip high", 32'h1, r.skip);
    exec(odp_pkg::OP_OUT_KEY, 4'hE, 4'h0);
    chk("k oe", 32'h1, pins_oe.dbit[3]);
    exec(odp_pkg::OP_IN_KEY, 4'hF, 4'h0);
    chk("k in low", 32'h0, r.acc);
    exec(odp_pkg::OP_OUT_KEY, 4'h1, 4'h0);
    exec(odp_pkg::OP_IN_KEY, 4'hE, 4'h0);
    chk("k in high", 32'h1, r.acc);
    // Clock enable low must freeze the latches
    @(posedge aclk);
    ce <= 1'h0;
    exec(odp_pkg::OP_OUT_KEY, 4'h0, 4'h0);
    chk("ce hold", 32'h0, pins_oe.dbit[3]);
    @(posedge aclk);
    ce <= 1'h1;
  endtask
  task automatic t_wake;
    axi_wr(odp_pkg::OFF_WAKE_MASK_0, 32'h1);
    @(posedge aclk);
    ext.quad0 <= 4'hE;
    repeat (3) @(posedge aclk);
    #1 chk("wake on", 32'h1, key_wake);
    ext.quad0 <= 4'hD;
    repeat (3) @(posedge aclk);
    #1 chk("wake masked", 32'h0, key_wake);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    #1;
    t_reset;
    t_regs;
    t_ports;
    t_dbits;
    t_shared;
    t_wake;
    conclude;
  end
  // Whole run is well under a thousand cycles; this is far beyond it
  initial begin
    #100000;
    fail_count++;
    conclude;
  end
endmodule
